// ===== core/dpsc_pkg.sv
// Constants and types for the power-down and self-refresh temperature block
package dpsc_pkg;

  // ------------------------------------------------------------------
  // Mode register 2 field positions
  // ------------------------------------------------------------------
  localparam int unsigned MR2_AUTO_BIT  = 6;
  localparam int unsigned MR2_MANUAL_BIT = 7;

  // ------------------------------------------------------------------
  // Timing figures
  // ------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS   = 10000;
  localparam int unsigned XPDLL_MIN_CK    = 10;
  localparam int unsigned XPDLL_MIN_PS    = 24000;
  localparam int unsigned XPDLL_TIME_CK   = (XPDLL_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned XPDLL_CK        = (XPDLL_MIN_CK > XPDLL_TIME_CK) ?
                                            XPDLL_MIN_CK : XPDLL_TIME_CK;
  localparam int unsigned SIMPLE_PDEN_CK  = 1;
  localparam int unsigned BURST_TAIL_CK   = 4;
  localparam int unsigned CHOP_TAIL_CK    = 2;
  localparam int unsigned AP_EXTRA_CK     = 1;
  localparam int unsigned REFI_NORMAL_MS  = 64;
  localparam int unsigned REFI_EXTEND_MS  = 32;

  localparam int unsigned CNT_W = 8;
  localparam int unsigned NUM_BANKS = 8;

  // ------------------------------------------------------------------
  // Commands as decoded by the command front end
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    DPSC_CMD_NOP, DPSC_CMD_DES, DPSC_CMD_ACT, DPSC_CMD_PRE, DPSC_CMD_PREA,
    DPSC_CMD_REF, DPSC_CMD_MRS, DPSC_CMD_MPR, DPSC_CMD_ZQ, DPSC_CMD_RD,
    DPSC_CMD_RDAP, DPSC_CMD_WR, DPSC_CMD_WRAP
  } dpsc_cmd_e;

  // Power state
  typedef enum logic [1:0] {
    DPSC_ST_AWAKE, DPSC_ST_ACT_PD, DPSC_ST_PRE_PD_FAST, DPSC_ST_PRE_PD_SLOW
  } dpsc_state_e;

  // Bounded add used by every latency sum
  function automatic logic [CNT_W-1:0] dpsc_sat(input int unsigned v);
    dpsc_sat = (v > 255) ? 8'hFF : CNT_W'(v);
  endfunction

endpackage

// ===== core/dpsc_top.sv
// Power-down entry/exit and self-refresh temperature control for the device
`timescale 1ns/10ps
module dpsc_top
  import dpsc_pkg::*;
#(
  parameter int unsigned CPDED_CK = 1
) (
  // Clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             nrst_in,
  // Pins, not yet synchronised; two flops deep below
  input  wire logic             cke_pin_in,
  input  wire logic             reset_pin_n_in,
  // Decoded command, same clock
  input  wire logic [3:0]       cmd_in,
  input  wire logic [2:0]       cmd_bank_in,
  // Mode settings, same clock
  input  wire logic [7:0]       mr2_low_in,
  input  wire logic             fast_exit_in,
  input  wire logic             fixed_chop_four_setting_in,
  input  wire logic             dll_locked_in,
  input  wire logic [CNT_W-1:0] read_latency_in,
  input  wire logic [CNT_W-1:0] write_latency_in,
  input  wire logic [CNT_W-1:0] write_recovery_in,
  input  wire logic [CNT_W-1:0] mod_delay_in,
  input  wire logic [CNT_W-1:0] anpd_delay_in,
  // Status
  output logic                  powered_down_out,
  output logic [1:0]            pd_state_out,
  output logic                  buffers_off_out,
  output logic                  dll_enable_out,
  output logic                  odt_async_out,
  output logic                  dll_reset_needed_out,
  output logic                  automatic_refresh_rate_enable_out,
  output logic                  manual_extended_range_flag_out,
  output logic                  extended_range_ok_out,
  output logic                  mode_illegal_out,
  output logic                  entry_violation_out,
  output logic                  cmd_violation_out
);

  // ------------------------------------------------------------------
  // Pin synchronisers: first stage is read only by the second
  // ------------------------------------------------------------------
  logic [1:0] cke_sync_q, rstp_sync_q;
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cke_sync_q  <= 2'h3;
      rstp_sync_q <= 2'h3;
    end else begin
      cke_sync_q  <= {cke_sync_q[0], cke_pin_in};
      rstp_sync_q <= {rstp_sync_q[0], reset_pin_n_in};
    end
  end
  wire logic cke_s  = cke_sync_q[1];
  wire logic rstp_s = rstp_sync_q[1];

  // Command helper decodes, used several times
  function automatic logic is_idle_cmd(input logic [3:0] c);
    is_idle_cmd = (c == DPSC_CMD_NOP) || (c == DPSC_CMD_DES);
  endfunction

  // ------------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------------
  dpsc_state_e        st_q, st_d;
  logic               cke_prev_q, cke_prev_d;
  logic [NUM_BANKS-1:0] open_q, open_d;
  logic [CNT_W-1:0]   gate_q, gate_d;      // Remaining cycles before entry is legal
  logic               busy_q, busy_d;      // Read/write/MRS style burst still running
  logic [CNT_W-1:0]   cped_q, cped_d;
  logic [CNT_W-1:0]   xit_q, xit_d;        // Async-termination hold after slow exit
  logic               dllrst_q, dllrst_d;
  logic               ent_viol_q, ent_viol_d;
  logic               cmd_viol_q, cmd_viol_d;
  logic               refpd_q, refpd_d;    // Power-down exited since the last entry; lengthens a refresh's entry gap

  // Mode register 2 view
  wire logic auto_rate = mr2_low_in[MR2_AUTO_BIT];
  wire logic man_ext   = mr2_low_in[MR2_MANUAL_BIT];

  // Next-state logic for power-down control
  always_comb begin
    int unsigned tail;
    tail       = fixed_chop_four_setting_in ? CHOP_TAIL_CK : BURST_TAIL_CK;
    st_d       = st_q;
    cke_prev_d = cke_s;
    open_d     = open_q;
    busy_d     = busy_q;
    gate_d     = (gate_q != '0) ? gate_q - 1'b1 : gate_q;
    cped_d     = (cped_q != '0) ? cped_q - 1'b1 : cped_q;
    xit_d      = (xit_q != '0) ? xit_q - 1'b1 : xit_q;
    dllrst_d   = dllrst_q;
    ent_viol_d = 1'b0;
    cmd_viol_d = 1'b0;
    refpd_d    = refpd_q;
    if (gate_q <= CNT_W'(SIMPLE_PDEN_CK)) begin
      busy_d = 1'b0;
    end
    if (!rstp_s) begin
      // Reset pin forces the device out of power-down
      st_d   = DPSC_ST_AWAKE;
      open_d = '0;
      gate_d = '0;
      busy_d = 1'b0;
    end else if (st_q == DPSC_ST_AWAKE) begin
      if (cke_s) begin
        // Per-command latency reloads the single gate_q down-counter; bank work completes anyway
        case (cmd_in)
          DPSC_CMD_ACT: begin
            open_d[cmd_bank_in] = 1'b1;
            gate_d = dpsc_sat(SIMPLE_PDEN_CK);
          end
          DPSC_CMD_PRE: begin
            open_d[cmd_bank_in] = 1'b0;
            gate_d = dpsc_sat(SIMPLE_PDEN_CK);
          end
          DPSC_CMD_PREA: begin
            open_d = '0;
            gate_d = dpsc_sat(SIMPLE_PDEN_CK);
          end
          DPSC_CMD_REF: begin
            gate_d = refpd_q ? dpsc_sat(XPDLL_CK) : dpsc_sat(SIMPLE_PDEN_CK);
          end
          DPSC_CMD_MRS, DPSC_CMD_MPR, DPSC_CMD_ZQ: begin
            gate_d = mod_delay_in;
            busy_d = 1'b1;
          end
          DPSC_CMD_RD, DPSC_CMD_RDAP: begin
            gate_d = dpsc_sat(read_latency_in + BURST_TAIL_CK + 1);
            busy_d = 1'b1;
          end
          DPSC_CMD_WR: begin
            gate_d = dpsc_sat(write_latency_in + tail + write_recovery_in);
            busy_d = 1'b1;
          end
          DPSC_CMD_WRAP: begin
            gate_d = dpsc_sat(write_latency_in + tail + write_recovery_in
                              + AP_EXTRA_CK);
            busy_d = 1'b1;
          end
          default: begin
          end
        endcase
        if (cmd_in == DPSC_CMD_RDAP || cmd_in == DPSC_CMD_WRAP) begin
          open_d[cmd_bank_in] = 1'b0;
        end
      end else if (cke_prev_q) begin
        // Falling clock-enable edge: entry attempt
        if (!is_idle_cmd(cmd_in) || gate_q > CNT_W'(SIMPLE_PDEN_CK) || busy_q) begin
          ent_viol_d = 1'b1;
        end
        if (is_idle_cmd(cmd_in)) begin
          cped_d  = CNT_W'(CPDED_CK);
          refpd_d = 1'b0;
          if (!dll_locked_in) begin
            dllrst_d = 1'b1;
          end
          if (open_q != '0) begin
            st_d = DPSC_ST_ACT_PD;
          end else if (fast_exit_in) begin
            st_d = DPSC_ST_PRE_PD_FAST;
          end else begin
            st_d = DPSC_ST_PRE_PD_SLOW;
          end
        end
      end
      if (cke_s && dllrst_q && cmd_in == DPSC_CMD_MRS) begin
        dllrst_d = 1'b0;
      end
    end else begin
      if (cped_q != '0 && !is_idle_cmd(cmd_in)) begin
        cmd_viol_d = 1'b1;
      end
      if (cke_s) begin
        if (!is_idle_cmd(cmd_in)) begin
          cmd_viol_d = 1'b1;
        end
        if (st_q == DPSC_ST_PRE_PD_SLOW) begin
          xit_d = dpsc_sat(anpd_delay_in + XPDLL_CK);
        end
        refpd_d = 1'b1;
        st_d    = DPSC_ST_AWAKE;
      end
    end
  end

  // Register the power-down state
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q       <= DPSC_ST_AWAKE;
      cke_prev_q <= 1'b1;
      open_q     <= '0;
      busy_q     <= 1'b0;
      gate_q     <= '0;
      cped_q     <= '0;
      xit_q      <= '0;
      dllrst_q   <= 1'b0;
      ent_viol_q <= 1'b0;
      cmd_viol_q <= 1'b0;
      refpd_q    <= 1'b0;
    end else begin
      st_q       <= st_d;
      cke_prev_q <= cke_prev_d;
      open_q     <= open_d;
      busy_q     <= busy_d;
      gate_q     <= gate_d;
      cped_q     <= cped_d;
      xit_q      <= xit_d;
      dllrst_q   <= dllrst_d;
      ent_viol_q <= ent_viol_d;
      cmd_viol_q <= cmd_viol_d;
      refpd_q    <= refpd_d;
    end
  end

  // ------------------------------------------------------------------
  // Output flops
  // ------------------------------------------------------------------
  logic [11:0] out_d, out_q;
  always_comb begin
    logic pd;
    pd = (st_d != DPSC_ST_AWAKE);
    out_d[0]   = pd;
    out_d[2:1] = st_d;
    out_d[3]   = pd;
    out_d[4]   = (st_d != DPSC_ST_PRE_PD_SLOW);
    // Async window opens with the slow entry; the anpd lead is on the controller
    out_d[5]   = (st_d == DPSC_ST_PRE_PD_SLOW) || (xit_d != '0);
    out_d[6]   = dllrst_d;
    out_d[7]   = auto_rate & ~man_ext;
    out_d[8]   = man_ext & ~auto_rate;
    // Extended range self refresh allowed by either option
    out_d[9]   = auto_rate | man_ext;
    out_d[10]  = auto_rate & man_ext;
    out_d[11]  = ent_viol_d | cmd_viol_d;
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      out_q <= 12'h010;
    end else begin
      out_q <= out_d;
    end
  end

  assign powered_down_out                  = out_q[0];
  assign pd_state_out                      = out_q[2:1];
  assign buffers_off_out                   = out_q[3];
  assign dll_enable_out                    = out_q[4];
  assign odt_async_out                     = out_q[5];
  assign dll_reset_needed_out              = out_q[6];
  assign automatic_refresh_rate_enable_out = out_q[7];
  assign manual_extended_range_flag_out    = out_q[8];
  assign extended_range_ok_out             = out_q[9];
  assign mode_illegal_out                  = out_q[10];
  assign entry_violation_out               = ent_viol_q;
  assign cmd_violation_out                 = cmd_viol_q;

endmodule // dpsc_top

// ===== testbench/dpsc_chk.sv
// Checker for power-down state and mode outputs of the block
`timescale 1ns/10ps
module dpsc_chk
  import dpsc_pkg::*;
#(
  parameter int unsigned CPDED_CK = 1
) (
  // Clock and reset
  input wire logic       clk_sys_in,
  input wire logic       nrst_in,
  // Inputs seen by the block
  input wire logic       cke_pin_in,
  input wire logic [3:0] cmd_in,
  input wire logic [7:0] mr2_low_in,
  input wire logic       fast_exit_in,
  // Status outputs
  input wire logic       powered_down_out,
  input wire logic [1:0] pd_state_out,
  input wire logic       buffers_off_out,
  input wire logic       dll_enable_out,
  input wire logic       odt_async_out,
  input wire logic       mode_illegal_out
);
  // Clock-enable as the block sees it, two edges late, plus the edge before that
  logic [2:0] cke_q;
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cke_q <= 3'h7;
    end else begin
      cke_q <= {cke_q[1:0], cke_pin_in};
    end
  end
  // Entry qualifiers; reset pin held high by the bench
  wire idle = (cmd_in == DPSC_CMD_NOP) || (cmd_in == DPSC_CMD_DES);
  // Entry needs a falling edge: a low level refused earlier gives no second try
  wire down = !cke_q[1] && cke_q[2] && !powered_down_out;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  // Relations between inputs and status
  AST_ILLEGAL: assert property ($past(nrst_in) |-> mode_illegal_out ==
    ($past(mr2_low_in[6]) && $past(mr2_low_in[7]))) else $error("illegal flag wrong");
  AST_ENTRY: assert property (down && idle |=> powered_down_out)
    else $error("no power-down entry");
  AST_STAY: assert property (!powered_down_out && (cke_q[1] || !idle) |=> !powered_down_out)
    else $error("entry without low clock-enable and idle command");
  AST_EXIT: assert property (powered_down_out && cke_q[1] && idle |=> !powered_down_out)
    else $error("no power-down exit");
  AST_BUF_OFF: assert property (buffers_off_out == powered_down_out)
    else $error("buffers not tied to power-down");
  AST_KIND: assert property (down && idle |=> pd_state_out == 2'h1 ||
    pd_state_out == {1'b1, !$past(fast_exit_in)}) else $error("wrong power-down kind");
  AST_DLL_OFF: assert property (dll_enable_out == (pd_state_out != 2'h3))
    else $error("dll enable wrong");
  AST_ODT_TAIL: assert property ($past(pd_state_out) == 2'h3 && pd_state_out == 2'h0 |->
    odt_async_out [*8]) else $error("termination left asynchronous mode early");
  // Main scenarios reached
  CV_ACT: cover property (pd_state_out == 2'h1);
  CV_FAST: cover property (pd_state_out == 2'h2);
  CV_SLOW: cover property (pd_state_out == 2'h3);
endmodule // dpsc_chk
bind dpsc_top dpsc_chk #(.CPDED_CK(CPDED_CK)) u_chk (.clk_sys_in, .nrst_in, .cke_pin_in,
  .cmd_in, .mr2_low_in, .fast_exit_in, .powered_down_out, .pd_state_out, .buffers_off_out,
  .dll_enable_out, .odt_async_out, .mode_illegal_out);

// ===== testbench/dpsc_ctl.sv
// Memory controller model driving clock-enable and commands
`timescale 1ns/10ps
module dpsc_ctl
  import dpsc_pkg::*;
(
  // Clock
  input  wire logic  clk_sys_in,
  // Controller pins
  output logic       cke_out,
  output logic [3:0] cmd_out,
  output logic [2:0] bank_out
);
  // Idle filler mixes NOP and DES so neither is relied upon
  function automatic logic [3:0] idl();
    idl = ($urandom % 2) ? DPSC_CMD_DES : DPSC_CMD_NOP;
  endfunction
  // Awake and idle from time zero
  initial {cke_out, cmd_out, bank_out} = {1'b1, 4'h0, 3'h0};
  // One command, then idle for the entry gap
  task automatic send(input logic [3:0] c, input logic [2:0] b, input int gap);
    @(negedge clk_sys_in);
    cmd_out = c;
    bank_out = b;
    repeat (gap + 1) begin
      @(negedge clk_sys_in);
      cmd_out = idl();
    end
  endtask
  // Power-down period; bad puts a refresh on the entry edges, late one inside the disable delay
  task automatic nap(input int hold, input bit bad, input bit late);
    @(negedge clk_sys_in);
    cke_out = 1'b0;
    for (int i = 0; i < hold; i++) begin
      @(negedge clk_sys_in);
      cmd_out = ((bad && i < 2) || (late && i == 2)) ? DPSC_CMD_REF : idl();
    end
    @(negedge clk_sys_in);
    cke_out = 1'b1;
    cmd_out = idl();
  endtask
endmodule // dpsc_ctl

// ===== testbench/dpsc_top_tb_top.sv
// Bench for the power-down and self-refresh temperature block
`timescale 1ns/10ps
module dpsc_top_tb_top import dpsc_pkg::*;;
  logic       clk_sys_in = 1'b0;
  logic       nrst_in = 1'b0;
  logic       cke, fast, chop, lock, viol_seen, exp_rst, pd, bufo, dlle, odta, dllr, ent_v;
  logic       cmd_v, cviol_seen;
  logic [3:0] cmd, mflags;
  logic [2:0] bank;
  logic [1:0] pds;
  logic [7:0] mr2, rl, wl, wr, mdly, anpd, open_q;
  int         err_count = 0;
  int         samples_checked = 0;
  // 100 MHz clock and sticky capture of entry and command faults
  always #5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    if (ent_v === 1'b1) viol_seen <= 1'b1;
    if (cmd_v === 1'b1) cviol_seen <= 1'b1;
  end
  dpsc_top #(.CPDED_CK(1)) dut (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .cke_pin_in(cke), .reset_pin_n_in(1'b1),
    .cmd_in(cmd), .cmd_bank_in(bank), .mr2_low_in(mr2), .fast_exit_in(fast),
    .fixed_chop_four_setting_in(chop), .dll_locked_in(lock), .read_latency_in(rl),
    .write_latency_in(wl), .write_recovery_in(wr), .mod_delay_in(mdly), .anpd_delay_in(anpd),
    .powered_down_out(pd), .pd_state_out(pds), .buffers_off_out(bufo), .dll_enable_out(dlle),
    .odt_async_out(odta), .dll_reset_needed_out(dllr),
    .automatic_refresh_rate_enable_out(mflags[3]), .manual_extended_range_flag_out(mflags[2]),
    .extended_range_ok_out(mflags[1]), .mode_illegal_out(mflags[0]),
    .entry_violation_out(ent_v), .cmd_violation_out(cmd_v));
  dpsc_ctl ctl (.clk_sys_in(clk_sys_in), .cke_out(cke), .cmd_out(cmd), .bank_out(bank));
  // Entry gap per command, in cycles
  function automatic int gate(input logic [3:0] c);
    case (c)
      DPSC_CMD_MRS, DPSC_CMD_MPR, DPSC_CMD_ZQ: gate = mdly;
      DPSC_CMD_RD, DPSC_CMD_RDAP: gate = rl + 5;
      DPSC_CMD_WR: gate = wl + (chop ? 2 : 4) + wr;
      DPSC_CMD_WRAP: gate = wl + (chop ? 2 : 4) + wr + 1;
      DPSC_CMD_REF: gate = 10;
      default: gate = 1;
    endcase
  endfunction
  // Expected mode flags and power-down kind
  function automatic logic [3:0] mode_exp(input logic [7:0] m);
    mode_exp = {m[6] & ~m[7], m[7] & ~m[6], m[6] | m[7], m[6] & m[7]};
  endfunction
  function automatic logic [1:0] kind(input logic [7:0] o, input logic f);
    kind = (|o) ? 2'h1 : (f ? 2'h2 : 2'h3);
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Watchdog at several times the expected run
  initial begin
    #200000;
    err_count++;
    test_done();
  end
  // Random commands and settings, each followed by a power-down period
  initial begin
    logic [3:0] c;
    logic [2:0] b;
    logic [1:0] es;
    bit         bad, early, late;
    void'($urandom(18));
    {fast, chop, lock, mr2, viol_seen, cviol_seen, exp_rst, open_q} = '0;
    {rl, wl, wr, mdly, anpd} = {8'h04, 32'h0};
    repeat (4) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    nrst_in = 1'b1;
    for (int i = 0; i < 48; i++) begin
      {mr2, fast, chop, lock, rl[1:0], wl[2:0], wr[2:0], mdly[2:0], anpd[2:0]} = 25'($urandom);
      repeat (2) @(negedge clk_sys_in);
      check({4'h0, mflags}, {4'h0, mode_exp(mr2)});
      bad = (i % 6 == 2);
      late = (i % 6 == 3);
      early = (i % 6 == 5);
      c = early ? 4'(DPSC_CMD_RD) : 4'h2 + 4'($urandom % 11);
      b = 3'($urandom);
      if (c == DPSC_CMD_MRS) exp_rst = 1'b0;
      ctl.send(c, b, early ? 0 : gate(c));
      case (c)
        DPSC_CMD_ACT: open_q[b] = 1'b1;
        DPSC_CMD_PRE, DPSC_CMD_RDAP, DPSC_CMD_WRAP: open_q[b] = 1'b0;
        DPSC_CMD_PREA: open_q = 8'h00;
        default: ;
      endcase
      {viol_seen, cviol_seen} = 2'h0;
      // A refresh on the entry edge is refused, so the block stays awake
      es = bad ? 2'h0 : kind(open_q, fast);
      fork
        ctl.nap(8 + $urandom % 8, bad, late);
        begin
          repeat (7) @(negedge clk_sys_in);
          exp_rst = exp_rst | (~lock & ~bad);
          check({4'h0, pds, pd, bufo}, {4'h0, es, {2{~bad}}});
          check({6'h0, dlle, dllr}, {6'h0, es != 2'h3, exp_rst});
        end
      join
      check({6'h0, cviol_seen, viol_seen}, {6'h0, late, bad | early});
      repeat (4) @(negedge clk_sys_in);
      check({5'h0, pd, dlle, odta}, {5'h0, 1'b0, 1'b1, es == 2'h3});
    end
    test_done();
  end
endmodule // dpsc_top_tb_top
